// File: design/pifb_defs.svh
// register offsets, bit positions, masks and reset values
// assumes byte addresses on a 32-bit AXI4-Lite bus
`ifndef PIFB_DEFS_SVH
`define PIFB_DEFS_SVH

// ===========================================
// offsets
`define PIFB_OFF_CTRL_A 32'h0000_0000
`define PIFB_OFF_CTRL_B 32'h0000_0004
`define PIFB_OFF_CTRL_C 32'h0000_0008
`define PIFB_OFF_GRP_A 32'h0000_000c

// ===========================================
// primary_irq_ctrl_a fields
`define PIFB_A_GLOBAL_E 0
`define PIFB_A_PIN_E 1
`define PIFB_A_CMP_E 2
`define PIFB_A_GRP0_E 3
`define PIFB_A_PIN_F 4
`define PIFB_A_CMP_F 5
`define PIFB_A_GRP0_F 6

// primary_irq_ctrl_b fields
`define PIFB_B_GRP1_E 0
`define PIFB_B_GRP2_E 1
`define PIFB_B_CONV_E 2
`define PIFB_B_TICK0_E 3
`define PIFB_B_GRP1_F 4
`define PIFB_B_GRP2_F 5
`define PIFB_B_CONV_F 6
`define PIFB_B_TICK0_F 7

// primary_irq_ctrl_c fields
`define PIFB_C_TICK1_E 0
`define PIFB_C_PIN_E 1
`define PIFB_C_SER_E 2
`define PIFB_C_ASYNC_E 3
`define PIFB_C_TICK1_F 4
`define PIFB_C_PIN_F 5
`define PIFB_C_SER_F 6
`define PIFB_C_ASYNC_F 7

// shared_group_irq_ctrl_a fields
`define PIFB_G_CMPP_E 0
`define PIFB_G_CMPA_E 1
`define PIFB_G_CMPP_F 4
`define PIFB_G_CMPA_F 5

// ===========================================
// implemented bits and reset values
`define PIFB_MASK_A 8'h7f
`define PIFB_MASK_B 8'hff
`define PIFB_MASK_C 8'hff
`define PIFB_MASK_G 8'h33
`define PIFB_RST_REG 8'h00
`define PIFB_RESP_OKAY 2'b00
`define PIFB_RESP_SLVERR 2'b10

`endif

// File: design/pifb_pkg.sv
// types shared by the flag and enable bank
// assumes nothing of its surroundings
`default_nettype none

package pifb_pkg;

    // ===========================================
    // one-cycle request pulses from the sources
    typedef struct packed {
        logic pin_a;
        logic comparator;
        logic tick0;
        logic converter;
        logic group1;
        logic group2;
        logic async_serial;
        logic serial_module;
        logic pin_b;
        logic tick1;
        logic std_timer_cmp_a;
        logic std_timer_cmp_p;
    } pifb_src_t;

    // ===========================================
    // flag and enable pairs waiting for the core
    typedef struct packed {
        logic pin_a;
        logic comparator;
        logic group0;
        logic tick0;
        logic converter;
        logic group1;
        logic group2;
        logic async_serial;
        logic serial_module;
        logic pin_b;
        logic tick1;
    } pifb_pend_t;

endpackage

`default_nettype wire

// File: design/pifb_top.sv
// request flag and enable bank with an AXI4-Lite register port
// assumes source pulses and bus signals synchronous to aclk
//
// Summary of operation
// - pin A event sets ctrl_a bit 4
// - pin A enable at ctrl_a bit 1
// - comparator flag at ctrl_a bit 5
// - group 0 flag at ctrl_a bit 6
// - tick 0 flag at ctrl_b bit 7
// - tick 0 enable at ctrl_b bit 3
// - group 2 flag at ctrl_b bit 5
// - group 2 enable at ctrl_b bit 1
// - group 1 enable at ctrl_b bit 0
// - async serial flag at ctrl_c bit 7
// - serial module flag at ctrl_c bit 6
// - pin B flag at ctrl_c bit 5
// - pin B enable at ctrl_c bit 1
// - tick 1 enable at ctrl_c bit 0
// - timer compare A flag at group bit 5
// - timer compare P flag at group bit 4
// - timer compare A enable at group bit 1
// - timer compare P enable at group bit 0
// - unimplemented bits read back as zero
// - timer matches share the group 0 request
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pifb_defs.svh"

module pifb_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire pifb_pkg::pifb_src_t src_req,
    output pifb_pkg::pifb_pend_t pending,
    output logic core_irq
);

    // ===========================================
    // storage
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] ctrl_c;
    logic [7:0] grp_a;
    logic [7:0] next_ctrl_a;
    logic [7:0] next_ctrl_b;
    logic [7:0] next_ctrl_c;
    logic [7:0] next_grp_a;
    logic [7:0] set_a;
    logic [7:0] set_b;
    logic [7:0] set_c;
    logic [7:0] set_g;
    logic grp0_act;
    logic grp0_act_q;
    logic aw_full;
    logic w_full;
    logic [31:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane;
    logic wr_go;
    logic wr_hit;
    logic [31:0] next_rdata;
    logic rd_hit;
    pifb_pkg::pifb_pend_t next_pending;

    // ===========================================
    // write channel capture
    assign wr_go = aw_full && w_full && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            awready <= 1'b0;
        end else if (awvalid && awready) begin
            aw_full <= 1'b1;
            awready <= 1'b0;
        end else if (wr_go) begin
            aw_full <= 1'b0;
            awready <= 1'b1;
        end else if (!aw_full) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr <= 32'h0000_0000;
        end else if (awvalid && awready) begin
            aw_addr <= awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full <= 1'b0;
            wready <= 1'b0;
        end else if (wvalid && wready) begin
            w_full <= 1'b1;
            wready <= 1'b0;
        end else if (wr_go) begin
            w_full <= 1'b0;
            wready <= 1'b1;
        end else if (!w_full) begin
            wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_byte <= 8'h00;
            w_lane <= 1'b0;
        end else if (wvalid && wready) begin
            w_byte <= wdata[7:0];
            w_lane <= wstrb[0];
        end
    end

    // ===========================================
    // write response
    always_comb begin
        case (aw_addr)
            `PIFB_OFF_CTRL_A: wr_hit = 1'b1;
            `PIFB_OFF_CTRL_B: wr_hit = 1'b1;
            `PIFB_OFF_CTRL_C: wr_hit = 1'b1;
            `PIFB_OFF_GRP_A: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
        end else if (wr_go) begin
            bvalid <= 1'b1;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bresp <= `PIFB_RESP_OKAY;
        end else if (wr_go) begin
            bresp <= wr_hit ? `PIFB_RESP_OKAY : `PIFB_RESP_SLVERR;
        end
    end

    // ===========================================
    // hardware set terms
    // group 0 is the shared request of both timer matches
    assign grp0_act = (grp_a[`PIFB_G_CMPA_F] && grp_a[`PIFB_G_CMPA_E])
        || (grp_a[`PIFB_G_CMPP_F] && grp_a[`PIFB_G_CMPP_E]);

    always_comb begin
        set_a = 8'h00;
        set_b = 8'h00;
        set_c = 8'h00;
        set_g = 8'h00;
        set_a[`PIFB_A_PIN_F] = src_req.pin_a;
        set_a[`PIFB_A_CMP_F] = src_req.comparator;
        set_a[`PIFB_A_GRP0_F] = grp0_act && !grp0_act_q;
        set_b[`PIFB_B_TICK0_F] = src_req.tick0;
        set_b[`PIFB_B_CONV_F] = src_req.converter;
        set_b[`PIFB_B_GRP2_F] = src_req.group2;
        set_b[`PIFB_B_GRP1_F] = src_req.group1;
        set_c[`PIFB_C_ASYNC_F] = src_req.async_serial;
        set_c[`PIFB_C_SER_F] = src_req.serial_module;
        set_c[`PIFB_C_PIN_F] = src_req.pin_b;
        set_c[`PIFB_C_TICK1_F] = src_req.tick1;
        set_g[`PIFB_G_CMPA_F] = src_req.std_timer_cmp_a;
        set_g[`PIFB_G_CMPP_F] = src_req.std_timer_cmp_p;
    end

    // ===========================================
    // next register values, a set beats a clear
    always_comb begin
        next_ctrl_a = ctrl_a;
        next_ctrl_b = ctrl_b;
        next_ctrl_c = ctrl_c;
        next_grp_a = grp_a;
        if (wr_go && w_lane) begin
            case (aw_addr)
                `PIFB_OFF_CTRL_A: begin
                    next_ctrl_a = w_byte & `PIFB_MASK_A;
                end
                `PIFB_OFF_CTRL_B: begin
                    next_ctrl_b = w_byte & `PIFB_MASK_B;
                end
                `PIFB_OFF_CTRL_C: begin
                    next_ctrl_c = w_byte & `PIFB_MASK_C;
                end
                `PIFB_OFF_GRP_A: begin
                    // flags only drop by software write
                    next_grp_a = w_byte & `PIFB_MASK_G;
                end
                default: begin
                    next_grp_a = grp_a;
                end
            endcase
        end
        next_ctrl_a = next_ctrl_a | set_a;
        next_ctrl_b = next_ctrl_b | set_b;
        next_ctrl_c = next_ctrl_c | set_c;
        next_grp_a = next_grp_a | set_g;
    end

    // ===========================================
    // register bank
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_a <= `PIFB_RST_REG;
        end else begin
            ctrl_a <= next_ctrl_a;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_b <= `PIFB_RST_REG;
        end else begin
            ctrl_b <= next_ctrl_b;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_c <= `PIFB_RST_REG;
        end else begin
            ctrl_c <= next_ctrl_c;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            grp_a <= `PIFB_RST_REG;
        end else begin
            grp_a <= next_grp_a;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            grp0_act_q <= 1'b0;
        end else begin
            grp0_act_q <= grp0_act;
        end
    end

    // ===========================================
    // read channel
    always_comb begin
        rd_hit = 1'b1;
        case (araddr)
            `PIFB_OFF_CTRL_A: next_rdata = {24'h000000, ctrl_a};
            `PIFB_OFF_CTRL_B: next_rdata = {24'h000000, ctrl_b};
            `PIFB_OFF_CTRL_C: next_rdata = {24'h000000, ctrl_c};
            `PIFB_OFF_GRP_A: next_rdata = {24'h000000, grp_a};
            default: begin
                next_rdata = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata <= 32'h0000_0000;
            rresp <= `PIFB_RESP_OKAY;
        end else if (arvalid && arready) begin
            rdata <= next_rdata;
            rresp <= rd_hit ? `PIFB_RESP_OKAY : `PIFB_RESP_SLVERR;
        end
    end

    // ===========================================
    // request forwarding to the core
    always_comb begin
        next_pending.pin_a = ctrl_a[`PIFB_A_PIN_F] && ctrl_a[`PIFB_A_PIN_E];
        next_pending.comparator = ctrl_a[`PIFB_A_CMP_F]
            && ctrl_a[`PIFB_A_CMP_E];
        next_pending.group0 = ctrl_a[`PIFB_A_GRP0_F]
            && ctrl_a[`PIFB_A_GRP0_E];
        next_pending.tick0 = ctrl_b[`PIFB_B_TICK0_F]
            && ctrl_b[`PIFB_B_TICK0_E];
        next_pending.converter = ctrl_b[`PIFB_B_CONV_F]
            && ctrl_b[`PIFB_B_CONV_E];
        next_pending.group1 = ctrl_b[`PIFB_B_GRP1_F]
            && ctrl_b[`PIFB_B_GRP1_E];
        next_pending.group2 = ctrl_b[`PIFB_B_GRP2_F]
            && ctrl_b[`PIFB_B_GRP2_E];
        next_pending.async_serial = ctrl_c[`PIFB_C_ASYNC_F]
            && ctrl_c[`PIFB_C_ASYNC_E];
        next_pending.serial_module = ctrl_c[`PIFB_C_SER_F]
            && ctrl_c[`PIFB_C_SER_E];
        next_pending.pin_b = ctrl_c[`PIFB_C_PIN_F] && ctrl_c[`PIFB_C_PIN_E];
        next_pending.tick1 = ctrl_c[`PIFB_C_TICK1_F]
            && ctrl_c[`PIFB_C_TICK1_E];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending <= '0;
        end else begin
            pending <= next_pending;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_irq <= 1'b0;
        end else begin
            core_irq <= ctrl_a[`PIFB_A_GLOBAL_E] && (|next_pending);
        end
    end

endmodule

`default_nettype wire

// File: sim/pifb_src_model.sv
// source model: turns a fire mask into one-cycle request pulses
// assumes fire is driven just after the rising edge of aclk
`timescale 1ns/1ps
`default_nettype none

module pifb_src_model (
    input wire logic aclk,
    input wire logic [11:0] fire,
    output wire pifb_pkg::pifb_src_t src_req
);
    logic [11:0] held = 12'h000;

    // ===========================================
    // one registered pulse per fire bit, msb is pin a
    always @(posedge aclk) begin
        held <= fire;
    end
    assign src_req = pifb_pkg::pifb_src_t'(held);
endmodule

`default_nettype wire

// File: sim/pifb_top_asserts.sv
// concurrent checks on the flag and enable bank ports
// assumes it is bound to every pifb_top instance
`timescale 1ns/1ps
`default_nettype none

module pifb_top_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic bvalid,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire pifb_pkg::pifb_src_t src_req,
    input wire pifb_pkg::pifb_pend_t pending,
    input wire logic core_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ===========================================
    // properties
    sequence s_rd_hs;
        rvalid && rready;
    endsequence
    property p_rd_end;
        s_rd_hs |=> !rvalid && arready;
    endproperty
    property p_rdata_hi;
        rvalid |-> rdata[31:8] == 24'h000000;
    endproperty
    property p_irq_pend;
        core_irq |-> pending != '0;
    endproperty
    property p_pin_a_cause;
        $rose(pending.pin_a) |-> $past(src_req.pin_a, 2) || $past(bvalid);
    endproperty
    property p_pin_b_cause;
        $rose(pending.pin_b) |-> $past(src_req.pin_b, 2) || $past(bvalid);
    endproperty
    property p_tick0_hold;
        $fell(pending.tick0) |-> $past(bvalid);
    endproperty
    property p_irq_fall;
        $fell(core_irq) |-> $past(bvalid);
    endproperty
    property p_group0_cause;
        $rose(pending.group0) |-> $past(src_req.std_timer_cmp_a, 3)
            || $past(src_req.std_timer_cmp_p, 3) || $past(bvalid)
            || $past(bvalid, 2);
    endproperty
    property p_reset_zero;
        $rose(aresetn) |-> pending == '0 && !core_irq;
    endproperty

    a_rd_end: assert property (p_rd_end)
        else $error("read channel did not return to idle");
    a_rdata_hi: assert property (p_rdata_hi)
        else $error("upper read data not zero");
    a_irq_pend: assert property (p_irq_pend)
        else $error("core irq without pending source");
    a_pin_a_cause: assert property (p_pin_a_cause)
        else $error("pin a pending without cause");
    a_pin_b_cause: assert property (p_pin_b_cause)
        else $error("pin b pending without cause");
    a_tick0_hold: assert property (p_tick0_hold)
        else $error("tick0 pending dropped without write");
    a_irq_fall: assert property (p_irq_fall)
        else $error("core irq dropped without write");
    a_group0_cause: assert property (p_group0_cause)
        else $error("group0 pending without timer cause");
    a_reset_zero: assert property (p_reset_zero)
        else $error("outputs not clear after reset");
endmodule

bind pifb_top pifb_top_asserts u_chk (
    .aclk(aclk), .aresetn(aresetn), .bvalid(bvalid), .rvalid(rvalid),
    .rready(rready), .arready(arready), .rdata(rdata),
    .src_req(src_req), .pending(pending), .core_irq(core_irq)
);

`default_nettype wire

// File: sim/pifb_top_test.sv
// self-checking bench for the flag and enable bank
// assumes pifb_top, the source model and the checker are compiled
`timescale 1ns/1ps
`default_nettype none
`include "pifb_defs.svh"

module pifb_top_test;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, core_irq;
    logic [31:0] awaddr, wdata, araddr, rdata, d, e;
    logic [1:0] bresp, rresp, r;
    logic [11:0] fire;
    logic [7:0] wdat [4];
    pifb_pkg::pifb_src_t src_req;
    pifb_pkg::pifb_pend_t pending;
    int err_count, checked, i, k;
    int src_off [12] = '{0, 0, 4, 4, 4, 4, 8, 8, 8, 8, 12, 12};
    int src_bit [12] = '{4, 5, 7, 6, 4, 5, 7, 6, 5, 4, 5, 4};
    logic [7:0] en_val [4] = '{8'h0e, 8'h0f, 8'h0f, 8'h03};
    logic [7:0] mask [4] = '{8'h7f, 8'hff, 8'hff, 8'h33};

    pifb_top uut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'h1), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .src_req(src_req), .pending(pending), .core_irq(core_irq)
    );
    pifb_src_model u_src (.aclk(aclk), .fire(fire), .src_req(src_req));

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // ===========================================
    // helpers
    function automatic logic [31:0] exp_reg(int j, logic [7:0] v);
        return {24'h000000, v & mask[j]};
    endfunction
    function automatic logic [10:0] exp_pend(int j);
        return j >= 10 ? 11'h100 : 11'h400 >> (j < 2 ? j : j + 1);
    endfunction
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [31:0] a, logic [7:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 40);
        rs = bresp;
        bready <= 1'b0;
        if (n >= 40) begin
            err_count++;
            summarize();
        end
    endtask
    task automatic rd(logic [31:0] a, output logic [31:0] v,
                      output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 40);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        if (n >= 40) begin
            err_count++;
            summarize();
        end
    endtask
    task automatic summarize();
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ===========================================
    // main sequence
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, wdata, araddr} = '0;
        fire = 12'h000;
        void'($urandom(66));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 5; i++) begin
            rd(32'(i * 4), d, r);
            chk("reset_value", d, 32'h0);
            chk("rresp", 32'(r), i == 4 ? 32'h2 : 32'h0);
        end
        for (i = 0; i < 4; i++) wdat[i] = 8'($urandom);
        for (i = 3; i >= 0; i--) wr(32'(i * 4), wdat[i], r);
        for (i = 0; i < 4; i++) begin
            rd(32'(i * 4), d, r);
            chk("readback", d, exp_reg(i, wdat[i]));
        end
        wr(32'h10, 8'hff, r);
        chk("bresp_unmapped", 32'(r), 32'(`PIFB_RESP_SLVERR));
        rd(32'h2, d, r);
        chk("rresp_unaligned", 32'(r), 32'(`PIFB_RESP_SLVERR));
        for (i = 0; i < 4; i++) wr(32'(i * 4), en_val[i], r);
        for (i = 0; i < 4; i++) begin
            rd(32'(i * 4), d, r);
            chk("enables", d, exp_reg(i, en_val[i]));
        end
        for (k = 0; k < 12; k++) begin
            @(posedge aclk);
            fire <= 12'h800 >> k;
            @(posedge aclk);
            fire <= 12'h000;
            repeat (4) @(posedge aclk);
            i = src_off[k] / 4;
            rd(32'(src_off[k]), d, r);
            e = exp_reg(i, en_val[i] | 8'(1 << src_bit[k]));
            chk("src_flag", d, e);
            chk("pend", {21'h0, pending}, {21'h0, exp_pend(k)});
            wr(32'(src_off[k]), en_val[i], r);
        end
        rd(32'h0, d, r);
        chk("group0_flag", d, 32'h4e);
        wr(32'h0, 8'h0e, r);
        @(posedge aclk);
        fire <= 12'h800;
        @(posedge aclk);
        fire <= 12'h000;
        repeat (4) @(posedge aclk);
        chk("pend_pin_a", 32'(pending.pin_a), 32'h1);
        chk("irq_global_off", 32'(core_irq), 32'h0);
        wr(32'h0, 8'h1f, r);
        repeat (3) @(posedge aclk);
        chk("irq_global_on", 32'(core_irq), 32'h1);
        wr(32'h0, 8'h1d, r);
        repeat (3) @(posedge aclk);
        chk("irq_enable_off", 32'(core_irq), 32'h0);
        wr(32'h4, 8'hff, r);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(32'h4, d, r);
        chk("midrun_reset", d, 32'h0);
        summarize();
    end
endmodule

`default_nettype wire
